/* File: common/necu_params.svh */
`ifndef NECU_PARAMS_SVH
`define NECU_PARAMS_SVH

// Bus register byte offsets
`define NECU_REG_INSTR 8'h00
`define NECU_REG_ACC 8'h04
`define NECU_REG_FLAGS 8'h08
`define NECU_REG_PTR 8'h0c
`define NECU_REG_SAVE 8'h10
`define NECU_REG_STROBE 8'h14
`define NECU_REG_TEMP 8'h18
`define NECU_REG_STATUS 8'h1c
`define NECU_REG_PAGE 8'h20

// Instruction word and page fields in the bus write data
`define NECU_OPC_HI 7
`define NECU_OPC_LO 0
`define NECU_IMM_HI 11
`define NECU_IMM_LO 8
`define NECU_PAGE_HI 3
`define NECU_PAGE_LO 0

// Full opcodes
`define NECU_OP_TABLE_LOOKUP 8'h01
`define NECU_OP_TEMP_TO_MEM 8'h12
`define NECU_OP_SHR_ZERO 8'h18
`define NECU_OP_SHR_ONE 8'h19
`define NECU_OP_SHL_ZERO 8'h1a
`define NECU_OP_SHL_ONE 8'h1b
`define NECU_OP_ACC_TO_PLO 8'h1c
`define NECU_OP_ACC_TO_PHI 8'h1d
`define NECU_OP_SWAP_LO 8'h1e
`define NECU_OP_SWAP_HI 8'h1f
`define NECU_OP_MEM_INC 8'h98
`define NECU_OP_MEM_DEC 8'h99
`define NECU_OP_PLO_INC 8'h9a
`define NECU_OP_PLO_DEC 8'h9b
`define NECU_OP_PHI_INC 8'h9c
`define NECU_OP_PHI_DEC 8'h9d
`define NECU_OP_STROBE_INC 8'h9e
`define NECU_OP_STROBE_DEC 8'h9f
`define NECU_OP_PLO_TO_ACC 8'hfd
`define NECU_OP_PHI_TO_ACC 8'hfe
`define NECU_OP_ACC_TO_STROBE 8'hae
`define NECU_OP_STROBE_TO_ACC 8'haa
`define NECU_OP_READ_CLR_HALT 8'hab
`define NECU_OP_READ_STATUS1 8'hac
`define NECU_OP_CHRONO_CLR 8'h04
`define NECU_OP_CHRONO_SET 8'h05
`define NECU_OP_DIVREL_CLR 8'h06
`define NECU_OP_DIVREL_SET 8'h07
`define NECU_OP_CARRY_CLR 8'hf0
`define NECU_OP_CARRY_SET 8'hf1
`define NECU_OP_MEM_TO_ACC 8'ha9
`define NECU_OP_ACC_TO_MEM 8'had

// Opcode groups keyed by the high nibble; ALU immediate keyed by bits 7..3
`define NECU_GRP_IMM_TO_MEM 4'h2
`define NECU_GRP_IMM_TO_ACC 4'h3
`define NECU_GRP_IMM_TO_PLO 4'hb
`define NECU_GRP_IMM_TO_PHI 4'hc
`define NECU_GRP_IMM_TO_STROBE 4'he
`define NECU_GRP_ALU_MEM 4'h8
`define NECU_GRP_ALU_IMM 5'h12
`define NECU_BOTH_BIT 3

// Constants
`define NECU_NIB_ZERO 4'h0
`define NECU_NIB_ONE 4'h1
`define NECU_SCF_ZERO 5'h00
`define NECU_SCF_HALT_CLR 5'h1e
`define NECU_SCF_ONE_CLR 5'h01
`define NECU_PAGE_RST 4'h0
`define NECU_OPC_RST 8'hff

`endif

/* File: common/necu_pkg.sv */
package necu_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_ACK = 2'b11,
        ST_EXEC2 = 2'b10
    } necu_state_t;

    // Operation select, equal to opcode bits 2..0
    typedef enum logic [2:0] {
        ALU_ADC, ALU_SBC, ALU_ADD, ALU_SUB,
        ALU_ADN, ALU_AND, ALU_XOR, ALU_OR
    } necu_alu_op_t;

    // Avalon-MM request group
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } necu_avm_req_t;

    // Result of the arithmetic/logic unit
    typedef struct packed {
        logic [3:0] res;
        logic carry;
        logic upd;
    } necu_alu_out_t;

endpackage

/* File: src/necu_alu.sv */
`timescale 1ns/100ps
module necu_alu (
    input necu_pkg::necu_alu_op_t op_i,
    input wire logic [3:0] a_i,
    input wire logic [3:0] b_i,
    input wire logic cin_i,
    output necu_pkg::necu_alu_out_t out_o
);
    import necu_pkg::*;

    logic [4:0] sum;

    // Subtraction is a plus inverted b, carry out is no-borrow
    always_comb begin
        unique case (op_i)
            ALU_ADC: sum = {1'b0, a_i} + {1'b0, b_i} + {4'h0, cin_i};
            ALU_SBC: sum = {1'b0, a_i} + {1'b0, ~b_i} + {4'h0, cin_i};
            ALU_ADD: sum = {1'b0, a_i} + {1'b0, b_i};
            ALU_SUB: sum = {1'b0, a_i} + {1'b0, ~b_i} + 5'h01;
            ALU_ADN: sum = {1'b0, a_i} + {1'b0, b_i};
            ALU_AND: sum = {1'b0, a_i & b_i};
            ALU_XOR: sum = {1'b0, a_i ^ b_i};
            ALU_OR: sum = {1'b0, a_i | b_i};
        endcase
    end

    // Only the first four operations touch the carry
    assign out_o.res = sum[3:0];
    assign out_o.carry = sum[4];
    assign out_o.upd = (op_i <= ALU_SUB);

endmodule

/* File: src/necu_core.sv */
`timescale 1ns/100ps
`include "necu_params.svh"

// Function
// - table lookup loads ROM word, two cycles
// - store temporary register into pointed nibble
// - shifts fill vacated bit per variant
// - memory inc/dec writes nibble and accumulator
// - add with carry updates carry
// - subtract uses carry as no-borrow
// - plain add updates carry
// - plain subtract ignores incoming carry
// - no-flag add keeps carry
// - AND keeps carry
// - exclusive OR keeps carry
// - inclusive OR keeps carry
// - opcode bit 3 also writes memory
// - ALU immediate forms take two cycles
// - accumulator and immediate move pointer nibbles
// - swap pointer nibble with save nibble
// - pointer nibbles step independently
// - strobe pointer load, read, step
// - halt status read clears flags 4..1
// - status one read clears flag zero
// - set/clear divider enable, chrono, carry
// - loads, stores and immediate transfers
// - pointer and save split in nibbles
module necu_core (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input necu_pkg::necu_avm_req_t avm_i,
    output logic [31:0] avm_readdata_o,
    output logic avm_waitrequest_o,
    output logic [11:0] rom_addr_o,
    input wire logic [7:0] rom_data_i,
    input wire logic [4:0] start_cond_i,
    input wire logic div_ovf_i,
    output logic halt_release_o,
    output logic chrono_run_o
);
    import necu_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State
    necu_state_t state_r;
    logic [7:0] opc_r;
    logic [3:0] imm_r;
    logic [3:0] acc_r;
    logic carry_r;
    logic [3:0] temp_r;
    logic [3:0] ptr_lo_r;
    logic [3:0] ptr_hi_r;
    logic [3:0] save_lo_r;
    logic [3:0] save_hi_r;
    logic [3:0] strobe_r;
    logic [3:0] page_r;
    logic divider_halt_release_enable_r;
    logic [4:0] scf_r;
    logic [3:0] ram_r [64];

    logic [5:0] ram_addr;
    logic [3:0] mem_rd;
    logic [3:0] opnd_b;
    logic [3:0] status_one;
    logic is_alu_mem;
    logic is_alu_imm;
    logic two_cyc;
    logic do_op;
    logic [3:0] acc_nxt;
    logic mem_we;
    logic [3:0] mem_wd;
    logic [4:0] scf_clr;
    necu_alu_out_t alu;

    ////////////////////////////////////////////////////////////////////
    // Decode
    // 64 nibbles: only two bits of the high pointer half reach the address
    assign ram_addr = {ptr_hi_r[1:0], ptr_lo_r};
    assign mem_rd = ram_r[ram_addr];
    assign is_alu_mem = (opc_r[7:4] == `NECU_GRP_ALU_MEM);
    assign is_alu_imm = (opc_r[7:3] == `NECU_GRP_ALU_IMM);
    assign two_cyc = is_alu_imm || (opc_r == `NECU_OP_TABLE_LOOKUP);
    assign opnd_b = is_alu_imm ? imm_r : mem_rd;
    assign status_one = {1'b0, chrono_run_o, divider_halt_release_enable_r, scf_r[0]};
    // Two-cycle work lands in the second cycle, after the ROM answered
    assign do_op = ce_i && (((state_r == ST_EXEC) && !two_cyc) ||
                            (state_r == ST_EXEC2));

    necu_alu u_alu (
        .op_i(necu_alu_op_t'(opc_r[2:0])),
        .a_i(acc_r),
        .b_i(opnd_b),
        .cin_i(carry_r),
        .out_o(alu)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus sequencer and waitrequest
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_r <= ST_IDLE;
            avm_waitrequest_o <= 1'b1;
        end else if (ce_i) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (avm_i.write && avm_i.address == `NECU_REG_INSTR &&
                        avm_i.byteenable[0]) begin
                        state_r <= ST_EXEC;
                    end else if (avm_i.read || avm_i.write) begin
                        state_r <= ST_ACK;
                        avm_waitrequest_o <= 1'b0;
                    end
                end
                ST_EXEC: begin
                    if (two_cyc) begin
                        state_r <= ST_EXEC2;
                    end else begin
                        state_r <= ST_ACK;
                        avm_waitrequest_o <= 1'b0;
                    end
                end
                ST_EXEC2: begin
                    state_r <= ST_ACK;
                    avm_waitrequest_o <= 1'b0;
                end
                ST_ACK: begin
                    state_r <= ST_IDLE;
                    avm_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // Instruction capture; the opcode lane alone is enough to issue
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            opc_r <= `NECU_OPC_RST;
            imm_r <= `NECU_NIB_ZERO;
        end else if (ce_i && state_r == ST_IDLE && avm_i.write &&
                     avm_i.address == `NECU_REG_INSTR &&
                     avm_i.byteenable[0]) begin
            opc_r <= avm_i.writedata[`NECU_OPC_HI:`NECU_OPC_LO];
            imm_r <= avm_i.writedata[`NECU_IMM_HI:`NECU_IMM_LO];
        end
    end

    // Page register for table lookups
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            page_r <= `NECU_PAGE_RST;
        end else if (ce_i && state_r == ST_IDLE && avm_i.write &&
                     avm_i.address == `NECU_REG_PAGE &&
                     avm_i.byteenable[0]) begin
            page_r <= avm_i.writedata[`NECU_PAGE_HI:`NECU_PAGE_LO];
        end
    end

    // Read data; unmapped offsets answer zero
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            avm_readdata_o <= 32'h0;
        end else if (ce_i && state_r == ST_IDLE && avm_i.read) begin
            unique case (avm_i.address)
                `NECU_REG_INSTR: avm_readdata_o <= {20'h0, imm_r, opc_r};
                `NECU_REG_ACC: avm_readdata_o <= {28'h0, acc_r};
                `NECU_REG_FLAGS:
                    avm_readdata_o <= {29'h0, divider_halt_release_enable_r, chrono_run_o, carry_r};
                `NECU_REG_PTR: avm_readdata_o <= {24'h0, ptr_hi_r, ptr_lo_r};
                `NECU_REG_SAVE:
                    avm_readdata_o <= {24'h0, save_hi_r, save_lo_r};
                `NECU_REG_STROBE: avm_readdata_o <= {28'h0, strobe_r};
                `NECU_REG_TEMP: avm_readdata_o <= {28'h0, temp_r};
                `NECU_REG_STATUS: avm_readdata_o <= {27'h0, scf_r};
                `NECU_REG_PAGE: avm_readdata_o <= {28'h0, page_r};
                default: avm_readdata_o <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Accumulator next value
    always_comb begin
        acc_nxt = acc_r;
        if (is_alu_mem || is_alu_imm) begin
            acc_nxt = alu.res;
        end else begin
            unique case (opc_r)
                `NECU_OP_SHR_ZERO: acc_nxt = {1'b0, acc_r[3:1]};
                `NECU_OP_SHR_ONE: acc_nxt = {1'b1, acc_r[3:1]};
                `NECU_OP_SHL_ZERO: acc_nxt = {acc_r[2:0], 1'b0};
                `NECU_OP_SHL_ONE: acc_nxt = {acc_r[2:0], 1'b1};
                `NECU_OP_MEM_INC: acc_nxt = mem_rd + `NECU_NIB_ONE;
                `NECU_OP_MEM_DEC: acc_nxt = mem_rd - `NECU_NIB_ONE;
                `NECU_OP_PLO_TO_ACC: acc_nxt = ptr_lo_r;
                `NECU_OP_PHI_TO_ACC: acc_nxt = ptr_hi_r;
                `NECU_OP_STROBE_TO_ACC: acc_nxt = strobe_r;
                `NECU_OP_READ_CLR_HALT: acc_nxt = scf_r[4:1];
                `NECU_OP_READ_STATUS1: acc_nxt = status_one;
                `NECU_OP_MEM_TO_ACC: acc_nxt = mem_rd;
                `NECU_OP_TABLE_LOOKUP: acc_nxt = rom_data_i[3:0];
                default: begin
                    if (opc_r[7:4] == `NECU_GRP_IMM_TO_ACC) begin
                        acc_nxt = opc_r[3:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            acc_r <= `NECU_NIB_ZERO;
        end else if (do_op) begin
            acc_r <= acc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data memory write port
    always_comb begin
        mem_we = 1'b0;
        mem_wd = acc_nxt;
        if (is_alu_mem && opc_r[`NECU_BOTH_BIT]) begin
            mem_we = 1'b1;
        end else if (opc_r == `NECU_OP_MEM_INC ||
                     opc_r == `NECU_OP_MEM_DEC) begin
            mem_we = 1'b1;
        end else if (opc_r == `NECU_OP_TEMP_TO_MEM) begin
            mem_we = 1'b1;
            mem_wd = temp_r;
        end else if (opc_r == `NECU_OP_ACC_TO_MEM) begin
            mem_we = 1'b1;
            mem_wd = acc_r;
        end else if (opc_r[7:4] == `NECU_GRP_IMM_TO_MEM) begin
            mem_we = 1'b1;
            mem_wd = opc_r[3:0];
        end
    end

    // No reset on the array: contents are data, not control
    always_ff @(posedge clock_i) begin
        if (do_op && mem_we) begin
            ram_r[ram_addr] <= mem_wd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Carry flag; anything not listed leaves it alone
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            carry_r <= 1'b0;
        end else if (do_op) begin
            if ((is_alu_mem || is_alu_imm) && alu.upd) begin
                carry_r <= alu.carry;
            end else if (opc_r == `NECU_OP_CARRY_CLR) begin
                carry_r <= 1'b0;
            end else if (opc_r == `NECU_OP_CARRY_SET) begin
                carry_r <= 1'b1;
            end
        end
    end

    // Temporary register takes the upper ROM nibble
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            temp_r <= `NECU_NIB_ZERO;
        end else if (do_op && opc_r == `NECU_OP_TABLE_LOOKUP) begin
            temp_r <= rom_data_i[7:4];
        end
    end

    // Table address replaces the low byte with accumulator and nibble
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rom_addr_o <= 12'h0;
        end else if (ce_i && state_r == ST_EXEC &&
                     opc_r == `NECU_OP_TABLE_LOOKUP) begin
            rom_addr_o <= {page_r, acc_r, mem_rd};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pointer low nibble and its save copy
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ptr_lo_r <= `NECU_NIB_ZERO;
            save_lo_r <= `NECU_NIB_ZERO;
        end else if (do_op) begin
            if (opc_r == `NECU_OP_ACC_TO_PLO) begin
                ptr_lo_r <= acc_r;
            end else if (opc_r[7:4] == `NECU_GRP_IMM_TO_PLO) begin
                ptr_lo_r <= opc_r[3:0];
            end else if (opc_r == `NECU_OP_SWAP_LO) begin
                ptr_lo_r <= save_lo_r;
                save_lo_r <= ptr_lo_r;
            end else if (opc_r == `NECU_OP_PLO_INC) begin
                ptr_lo_r <= ptr_lo_r + `NECU_NIB_ONE;
            end else if (opc_r == `NECU_OP_PLO_DEC) begin
                ptr_lo_r <= ptr_lo_r - `NECU_NIB_ONE;
            end
        end
    end

    // Pointer high nibble and its save copy
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ptr_hi_r <= `NECU_NIB_ZERO;
            save_hi_r <= `NECU_NIB_ZERO;
        end else if (do_op) begin
            if (opc_r == `NECU_OP_ACC_TO_PHI) begin
                ptr_hi_r <= acc_r;
            end else if (opc_r[7:4] == `NECU_GRP_IMM_TO_PHI) begin
                ptr_hi_r <= opc_r[3:0];
            end else if (opc_r == `NECU_OP_SWAP_HI) begin
                ptr_hi_r <= save_hi_r;
                save_hi_r <= ptr_hi_r;
            end else if (opc_r == `NECU_OP_PHI_INC) begin
                ptr_hi_r <= ptr_hi_r + `NECU_NIB_ONE;
            end else if (opc_r == `NECU_OP_PHI_DEC) begin
                ptr_hi_r <= ptr_hi_r - `NECU_NIB_ONE;
            end
        end
    end

    // Strobe pointer
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            strobe_r <= `NECU_NIB_ZERO;
        end else if (do_op) begin
            if (opc_r == `NECU_OP_ACC_TO_STROBE) begin
                strobe_r <= acc_r;
            end else if (opc_r[7:4] == `NECU_GRP_IMM_TO_STROBE) begin
                strobe_r <= opc_r[3:0];
            end else if (opc_r == `NECU_OP_STROBE_INC) begin
                strobe_r <= strobe_r + `NECU_NIB_ONE;
            end else if (opc_r == `NECU_OP_STROBE_DEC) begin
                strobe_r <= strobe_r - `NECU_NIB_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Chrono start and divider release enable
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            chrono_run_o <= 1'b0;
            divider_halt_release_enable_r <= 1'b0;
        end else if (do_op) begin
            if (opc_r == `NECU_OP_CHRONO_CLR) begin
                chrono_run_o <= 1'b0;
            end else if (opc_r == `NECU_OP_CHRONO_SET) begin
                chrono_run_o <= 1'b1;
            end else if (opc_r == `NECU_OP_DIVREL_CLR) begin
                divider_halt_release_enable_r <= 1'b0;
            end else if (opc_r == `NECU_OP_DIVREL_SET) begin
                divider_halt_release_enable_r <= 1'b1;
            end
        end
    end

    // Overflow wakes the core only while enabled
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            halt_release_o <= 1'b0;
        end else if (ce_i) begin
            halt_release_o <= divider_halt_release_enable_r & div_ovf_i;
        end
    end

    // Start-condition flags: an arriving event beats the read clear
    always_comb begin
        scf_clr = `NECU_SCF_ZERO;
        if (do_op && opc_r == `NECU_OP_READ_CLR_HALT) begin
            scf_clr = `NECU_SCF_HALT_CLR;
        end else if (do_op && opc_r == `NECU_OP_READ_STATUS1) begin
            scf_clr = `NECU_SCF_ONE_CLR;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            scf_r <= `NECU_SCF_ZERO;
        end else if (ce_i) begin
            scf_r <= (scf_r & ~scf_clr) | start_cond_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    sequence s_issue_two;
        ce_i && state_r == ST_EXEC && two_cyc;
    endsequence

    sequence s_read_req;
        ce_i && state_r == ST_IDLE && avm_i.read;
    endsequence

    chk_imm_two_cycle: assert property (s_issue_two |=>
        state_r == ST_EXEC2 && avm_waitrequest_o)
        else $error("two-cycle op skipped its second cycle");
    chk_read_answer: assert property (s_read_req ##1 ce_i |=>
        state_r == ST_IDLE && avm_waitrequest_o)
        else $error("read answer did not complete");
    chk_shift_fill: assert property (do_op &&
        opc_r == `NECU_OP_SHR_ONE |=> acc_r == {1'b1, $past(acc_r[3:1])})
        else $error("right shift fill wrong");
    chk_add_carry: assert property (do_op && is_alu_mem &&
        opc_r[2:0] == ALU_ADD |=>
        {carry_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(opnd_b)})
        else $error("add sum or carry wrong");
    chk_sub_borrow: assert property (do_op &&
        (is_alu_mem || is_alu_imm) && opc_r[2:0] == ALU_SUB |=>
        {carry_r, acc_r} ==
        {1'b0, $past(acc_r)} + {1'b0, ~$past(opnd_b)} + 5'h01)
        else $error("subtract result or borrow wrong");
    chk_logic_keeps: assert property (do_op &&
        (is_alu_mem || is_alu_imm) && opc_r[2] |=> $stable(carry_r))
        else $error("carry changed by a no-flag op");
    chk_inc_both: assert property (do_op &&
        opc_r == `NECU_OP_MEM_INC |=> acc_r == $past(mem_rd) + 4'h1 &&
        ram_r[$past(ram_addr)] == acc_r)
        else $error("memory increment mismatch");
    chk_table_addr: assert property (ce_i && state_r == ST_EXEC &&
        opc_r == `NECU_OP_TABLE_LOOKUP |=>
        rom_addr_o == {$past(page_r), $past(acc_r), $past(mem_rd)})
        else $error("table address wrong");
    chk_swap_low: assert property (do_op &&
        opc_r == `NECU_OP_SWAP_LO |=>
        ptr_lo_r == $past(save_lo_r) && save_lo_r == $past(ptr_lo_r))
        else $error("low nibble swap wrong");
    chk_halt_clear: assert property (do_op &&
        opc_r == `NECU_OP_READ_CLR_HALT |=>
        scf_r[4:1] == $past(start_cond_i[4:1]) && acc_r == $past(scf_r[4:1]))
        else $error("halt status not cleared");
    chk_status_one: assert property (do_op &&
        opc_r == `NECU_OP_READ_STATUS1 |=> scf_r[0] == $past(start_cond_i[0])
        && scf_r[4:1] == ($past(scf_r[4:1]) | $past(start_cond_i[4:1])))
        else $error("status one clear wrong");
    // Rising edge only: with the enable low the output may outlive divider_halt_release_enable
    chk_release_gate: assert property ($rose(halt_release_o) |->
        $past(divider_halt_release_enable_r))
        else $error("halt release while disabled");

endmodule

/* File: testbench/necu_rom_model.sv */
`timescale 1ns/100ps
// Program ROM stand-in: each word is a fixed function of its address
module necu_rom_model (
    input wire logic [11:0] addr_i,
    output logic [7:0] data_o
);
    // Combinational read, settled in the same cycle the address moves
    assign data_o = addr_i[7:0] ^ 8'h5a;
endmodule

/* File: testbench/test_nibble_cpu_execute_unit.sv */
`timescale 1ns/100ps
`include "necu_params.svh"
module test_nibble_cpu_execute_unit;
    import necu_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    necu_avm_req_t avm_i = '0;
    logic [31:0] rdata;
    logic wait_req;
    logic [11:0] rom_addr;
    logic [7:0] rom_data;
    logic [4:0] start_cond = 5'h00;
    logic div_ovf = 1'b0;
    logic ce = 1'b1;
    logic halt_rel;
    logic chrono_run;
    logic [31:0] got;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    // Rows: {instruction word, register read after it, expected byte}
    logic [27:0] rows [45] = '{
        28'h035_04_05, 28'h0f1_08_01, 28'hc90_04_02, 28'h0ff_08_01,
        28'h393_04_0f, 28'h0ff_08_00, 28'h695_04_06, 28'h019_04_0b,
        28'h01a_04_06, 28'h0b4_0c_04, 28'h0c1_0c_14, 28'h0ad_04_06,
        28'h098_04_07, 28'h08a_04_0e, 28'h030_04_00, 28'h0a9_04_0e,
        28'h01e_0c_10, 28'h0ff_10_04, 28'h09b_0c_1f, 28'h0e9_14_09,
        28'h09e_14_0a, 28'h023_04_0e, 28'h001_04_09, 28'h0ff_18_0b,
        28'h012_04_09, 28'h0a9_04_0b, 28'h005_08_02, 28'h007_08_06,
        28'h0ac_04_07, 28'h0ff_1c_04, 28'h0ab_04_02,
        28'h0f1_08_07, 28'h081_04_07, 28'h084_08_06, 28'h08e_04_09,
        28'h697_04_0f, 28'h0a9_04_09, 28'h099_04_08, 28'h01d_0c_8f,
        28'h09c_0c_9f, 28'h0fe_04_09, 28'h09f_14_09, 28'h035_04_05,
        28'h0aa_04_09, 28'h01f_10_94
    };

    // Free-running bench clock, 50 ns period
    always #25 clock_i = ~clock_i;

    necu_core DUT (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .ce_i(ce),
        .avm_i(avm_i),
        .avm_readdata_o(rdata),
        .avm_waitrequest_o(wait_req),
        .rom_addr_o(rom_addr),
        .rom_data_i(rom_data),
        .start_cond_i(start_cond),
        .div_ovf_i(div_ovf),
        .halt_release_o(halt_rel),
        .chrono_run_o(chrono_run)
    );

    necu_rom_model rom (
        .addr_i(rom_addr),
        .data_o(rom_data)
    );

    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One Avalon transfer; idles a cycle after so no signal moves twice
    task bus(input logic wr, input logic [7:0] addr, input logic [31:0] d);
        avm_i.read <= !wr;
        avm_i.write <= wr;
        avm_i.address <= addr;
        avm_i.writedata <= d;
        avm_i.byteenable <= 4'hf;
        do @(posedge clock_i); while (wait_req !== 1'b0);
        got = rdata;
        avm_i.read <= 1'b0;
        avm_i.write <= 1'b0;
        @(posedge clock_i);
    endtask

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard, well above the run length
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop;
        end
    end

    initial begin
        repeat (20) @(posedge clock_i);
        srst_i <= 1'b0;
        start_cond <= 5'h05;
        div_ovf <= 1'b1;
        @(posedge clock_i);
        start_cond <= 5'h00;
        bus(1'b0, `NECU_REG_ACC, 32'h0);
        check(got, 32'h0, "acc after reset");
        check(32'(halt_rel), 32'h0, "halt release gated");
        bus(1'b0, 8'h40, 32'h0);
        check(got, 32'h0, "unmapped read");
        $display("reset test done");
        // Each row issues one instruction and reads its effect back
        foreach (rows[i]) begin
            bus(1'b1, `NECU_REG_INSTR, {20'h0, rows[i][27:16]});
            bus(1'b0, rows[i][15:8], 32'h0);
            check(got, {24'h0, rows[i][7:0]}, "row");
        end
        check(32'(halt_rel), 32'h1, "halt release on");
        check(32'(chrono_run), 32'h1, "chrono run");
        bus(1'b0, `NECU_REG_STATUS, 32'h0);
        check(got, 32'h0, "status cleared");
        $display("instruction table test done");
        // Enable low: the request waits and a status event is lost
        ce <= 1'b0;
        start_cond <= 5'h02;
        fork
            bus(1'b1, `NECU_REG_INSTR, 32'h37);
            begin
                @(posedge clock_i);
                start_cond <= 5'h00;
                repeat (3) @(posedge clock_i);
                ce <= 1'b1;
            end
        join
        bus(1'b0, `NECU_REG_ACC, 32'h0);
        check(got, 32'h7, "acc after enable gap");
        bus(1'b0, `NECU_REG_STATUS, 32'h0);
        check(got, 32'h0, "status frozen by enable");
        $display("clock enable test done");
        // Reset in mid-run brings flags and release back to zero
        srst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        check(32'(halt_rel), 32'h0, "release after reset");
        bus(1'b0, `NECU_REG_FLAGS, 32'h0);
        check(got, 32'h0, "flags after reset");
        bus(1'b0, `NECU_REG_ACC, 32'h0);
        check(got, 32'h0, "acc after mid-run reset");
        $display("mid-run reset test done");
        report_and_stop;
    end
endmodule
